/* File: trigger_io_pkg.sv */
// Purpose: shared constants and types for the trigger and result I/O sequencer
// Assumes: 100 MHz pclk, 32-bit APB slave with byte addresses
// Notes:   all timing figures below are in their own units; cycle counts derive from them
package trigger_io_pkg;

  // ==========================================================================
  // clock and time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_US_NS     = 1000;
  localparam int CYCLES_PER_US  = (TICK_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_100US   = 100;
  localparam int HUNDRED_US_PER_MS = 10;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FLASH   = 8'h04;
  localparam logic [7:0] OFF_SHUTTER = 8'h08;
  localparam logic [7:0] OFF_READY_T = 8'h0C;
  localparam logic [7:0] OFF_STROBE  = 8'h10;
  localparam logic [7:0] OFF_DATA    = 8'h14;
  localparam logic [7:0] OFF_RESULT  = 8'h18;
  localparam logic [7:0] OFF_CMD     = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // ==========================================================================
  // field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_BUF_BIT    = 2;
  localparam int CTRL_FAFTER_BIT = 3;
  localparam int CTRL_HS_BIT     = 4;
  localparam int LO_LSB          = 0;
  localparam int HI_LSB          = 16;
  localparam int RESULT_ALL_BIT  = 16;
  localparam int CMD_DONE_BIT    = 0;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_FLASH_ACT  = 16'h0000;
  localparam logic [15:0] RST_FLASH_DUR  = 16'h000A;
  localparam logic [15:0] RST_SHUTTER    = 16'h03E8;
  localparam logic [15:0] RST_READY_T_MS = 16'h000A;
  localparam logic [15:0] RST_STR_DELAY  = 16'h0001;
  localparam logic [15:0] RST_STR_LEN    = 16'h0005;
  localparam logic [15:0] RST_DATA_DUR   = 16'h000A;
  localparam logic [15:0] RST_TIMEOUT    = 16'h0064;

  // extra time margins used when deciding a flash stays on for good
  localparam int REFRESH_US_DEF = 16000;
  localparam int PROC_US_DEF    = 1000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_TWO_CAPTURE_TRIGGER,
    MODE_ONE_CAPTURE_TRIGGER
  } cam_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    cam_mode_t mode;
    logic      buffered;
    logic      flash_after;
    logic      handshake;
  } cfg_t;

endpackage

/* File: time_base.sv */
// Purpose: 1 us, 100 us and 1 ms tick pulses from pclk
// Assumes: ticks are one pclk cycle wide
// Notes:   the slower ticks fall on the same cycle as a faster one
module time_base #(
  parameter int CYC_US = trigger_io_pkg::CYCLES_PER_US
) (
  input  wire logic pclk,      // system clock
  input  wire logic presetn,   // async reset, active low
  output logic      tick_us,   // 1 us pulse
  output logic      tick_100us,// 100 us pulse
  output logic      tick_ms    // 1 ms pulse
);
  import trigger_io_pkg::*;

  logic [7:0] cyc_cnt;
  logic [6:0] us_cnt;
  logic [3:0] hus_cnt;

  // ==========================================================================
  // cascaded prescalers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt    <= 8'h00;
      us_cnt     <= 7'h00;
      hus_cnt    <= 4'h0;
      tick_us    <= 1'b0;
      tick_100us <= 1'b0;
      tick_ms    <= 1'b0;
    end else begin
      tick_us    <= 1'b0;
      tick_100us <= 1'b0;
      tick_ms    <= 1'b0;
      if (cyc_cnt == 8'(CYC_US - 1)) begin
        cyc_cnt <= 8'h00;
        tick_us <= 1'b1;
        if (us_cnt == 7'(US_PER_100US - 1)) begin
          us_cnt     <= 7'h00;
          tick_100us <= 1'b1;
          if (hus_cnt == 4'(HUNDRED_US_PER_MS - 1)) begin
            hus_cnt <= 4'h0;
            tick_ms <= 1'b1;
          end else begin
            hus_cnt <= hus_cnt + 4'h1;
          end
        end else begin
          us_cnt <= us_cnt + 7'h01;
        end
      end else begin
        cyc_cnt <= cyc_cnt + 8'h01;
      end
    end
  end

endmodule

/* File: trigger_io_seq.sv */
// Purpose: capture trigger, flash and parallel result sequencer with an APB register file
// Assumes: triggers and acknowledge are asynchronous pins; processing end comes from software
// Notes:   one capture engine serves both cameras, so captures never overlap
// What this block does
// - buffered mode captures the next image while the previous one is processed
// - buffered triggers are taken only while capture-done is high
// - capture-done comes back high when a buffered capture finishes
// - capture during processing gives a ready pulse of programmable length, default 10 ms
// - no capture during processing holds ready high until the next accepted trigger
// - a second camera trigger waits until the first capture completes
// - two-trigger mode takes the camera triggers in either order
// - one-trigger dual mode ignores the trigger while any capture runs
// - one-trigger dual mode captures both images, then raises capture-done a and b
// - flash-before mode starts the flash after the delay, shutter follows it
// - flash-after mode opens the shutter first, flash follows
// - flash offset counts microseconds, flash length counts 100 us units
// - flash longer than shutter plus refresh plus processing stays on continuously
// - result port has sixteen lines plus one overall result line
// - ready starts a strobe delay in ms, strobe rises when it expires
// - without handshake strobe has set length, data held delay plus length at least
// - handshake timeout without acknowledge aborts output and raises error
// - with handshake strobe falls once acknowledge is seen
// - with handshake new data appears only after acknowledge is low again
// - non-buffered mode drops ready on an accepted trigger, raises it when done
module trigger_io_seq #(
  parameter int REFRESH_US = trigger_io_pkg::REFRESH_US_DEF,
  parameter int PROC_US    = trigger_io_pkg::PROC_US_DEF
) (
  input  wire logic                     pclk,               // system clock
  input  wire logic                     presetn,            // async reset, active low
  input  wire trigger_io_pkg::apb_req_t apb,                // apb request
  output logic [31:0]                   prdata,             // apb read data
  output logic                          pready,             // apb ready
  output logic                          pslverr,            // apb error, unmapped
  input  wire logic                     capture_trigger_a,  // camera a trigger pin
  input  wire logic                     capture_trigger_b,  // camera b trigger pin
  input  wire logic                     ack_in,             // handshake acknowledge pin
  output logic                          capture_done_a,     // camera a can take trigger
  output logic                          capture_done_b,     // camera b can take trigger
  output logic                          ready,              // inspection ready
  output logic                          shutter_internal_a, // camera a shutter
  output logic                          shutter_internal_b, // camera b shutter
  output logic                          light_strobe_a,     // flash a
  output logic                          light_strobe_b,     // flash b
  output logic                          result_strobe,      // result strobe
  output logic [15:0]                   result_lines,       // result data
  output logic                          overall_result_out, // overall result
  output logic                          error_out,          // handshake error
  output logic                          error_led           // error indicator
);
  import trigger_io_pkg::*;

  typedef enum {OUT_IDLE, OUT_DELAY, OUT_STROBE, OUT_HOLD, OUT_RELEASE} out_state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [19:0] ext(input logic [15:0] v);
    return {4'h0, v};
  endfunction

  logic        tick_us, tick_100us, tick_ms;
  cfg_t        cfg;
  logic [15:0] fl_act, fl_dur, sh_len, ready_t, str_dly, str_len, data_dur, tmo;
  logic [15:0] res_lines;
  logic        res_all;
  logic [2:0]  sync_a, sync_b, sync_k;
  logic        rise_a, rise_b, ack_lvl;
  logic        wr_acc, proc_done_cmd;
  logic        pend_a, pend_b, got_a, got_b, cap_active, cur_b;
  logic [19:0] t_us;
  logic        fl_started, flash;
  logic [15:0] fl_cnt;
  logic        flash_always;
  logic        proc_busy, buf_full, cap_during;
  logic [15:0] ready_cnt;
  logic        gate, acc_a, acc_b, cap_finish, set_done, proc_end, two_cam;
  logic [19:0] sh_start, fl_start, sh_end;
  out_state_t  out_st;
  logic [15:0] out_cnt, data_cnt;
  logic        start_pend, out_start;

  time_base u_time_base (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick_us    (tick_us),
    .tick_100us (tick_100us),
    .tick_ms    (tick_ms)
  );

  // ==========================================================================
  // pin synchronisers; only the second stage and later are read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'b000;
      sync_b <= 3'b000;
      sync_k <= 3'b000;
    end else begin
      sync_a <= {sync_a[1:0], capture_trigger_a};
      sync_b <= {sync_b[1:0], capture_trigger_b};
      sync_k <= {sync_k[1:0], ack_in};
    end
  end
  assign rise_a  = sync_a[1] & ~sync_a[2];
  assign rise_b  = sync_b[1] & ~sync_b[2];
  assign ack_lvl = sync_k[1];

  // ==========================================================================
  // apb slave: one wait-free access, answer flopped from the setup cycle
  assign wr_acc        = apb.psel & apb.penable & pready & apb.pwrite;
  assign proc_done_cmd = wr_acc & hit(apb.paddr, OFF_CMD) & apb.pwdata[CMD_DONE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb.psel & ~apb.penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb.psel & ~apb.penable) begin
        unique case (1'b1)
          hit(apb.paddr, OFF_CTRL):
            prdata <= {27'h0, cfg.handshake, cfg.flash_after, cfg.buffered, cfg.mode};
          hit(apb.paddr, OFF_FLASH):   prdata <= {fl_dur, fl_act};
          hit(apb.paddr, OFF_SHUTTER): prdata <= {16'h0000, sh_len};
          hit(apb.paddr, OFF_READY_T): prdata <= {16'h0000, ready_t};
          hit(apb.paddr, OFF_STROBE):  prdata <= {str_len, str_dly};
          hit(apb.paddr, OFF_DATA):    prdata <= {tmo, data_dur};
          hit(apb.paddr, OFF_RESULT):  prdata <= {15'h0000, res_all, res_lines};
          hit(apb.paddr, OFF_CMD):     prdata <= 32'h0000_0000;
          hit(apb.paddr, OFF_STATUS):
            prdata <= {23'h0, flash_always, error_out, out_st != OUT_IDLE, buf_full,
                       proc_busy, cap_active, ready, capture_done_b, capture_done_a};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // configuration and result registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg       <= '{mode: MODE_SINGLE, buffered: 1'b0, flash_after: 1'b0, handshake: 1'b0};
      fl_act    <= RST_FLASH_ACT;
      fl_dur    <= RST_FLASH_DUR;
      sh_len    <= RST_SHUTTER;
      ready_t   <= RST_READY_T_MS;
      str_dly   <= RST_STR_DELAY;
      str_len   <= RST_STR_LEN;
      data_dur  <= RST_DATA_DUR;
      tmo       <= RST_TIMEOUT;
      res_lines <= 16'h0000;
      res_all   <= 1'b0;
    end else if (wr_acc) begin
      if (hit(apb.paddr, OFF_CTRL)) begin
        cfg.mode        <= cam_mode_t'(apb.pwdata[CTRL_MODE_LSB +: 2]);
        cfg.buffered    <= apb.pwdata[CTRL_BUF_BIT];
        cfg.flash_after <= apb.pwdata[CTRL_FAFTER_BIT];
        cfg.handshake   <= apb.pwdata[CTRL_HS_BIT];
      end
      if (hit(apb.paddr, OFF_FLASH)) begin
        fl_act <= apb.pwdata[LO_LSB +: 16];
        fl_dur <= apb.pwdata[HI_LSB +: 16];
      end
      if (hit(apb.paddr, OFF_SHUTTER)) sh_len <= apb.pwdata[LO_LSB +: 16];
      if (hit(apb.paddr, OFF_READY_T)) ready_t <= apb.pwdata[LO_LSB +: 16];
      if (hit(apb.paddr, OFF_STROBE)) begin
        str_dly <= apb.pwdata[LO_LSB +: 16];
        str_len <= apb.pwdata[HI_LSB +: 16];
      end
      if (hit(apb.paddr, OFF_DATA)) begin
        data_dur <= apb.pwdata[LO_LSB +: 16];
        tmo      <= apb.pwdata[HI_LSB +: 16];
      end
      if (hit(apb.paddr, OFF_RESULT)) begin
        res_lines <= apb.pwdata[LO_LSB +: 16];
        res_all   <= apb.pwdata[RESULT_ALL_BIT];
      end
    end
  end

  // ==========================================================================
  // trigger acceptance; unbuffered also waits for processing to end
  assign two_cam  = cfg.mode != MODE_SINGLE;
  assign gate     = cfg.buffered ? ~buf_full : ~(proc_busy | buf_full);
  assign acc_a    = rise_a & capture_done_a & gate;
  assign acc_b    = rise_b & capture_done_b & gate & (cfg.mode == MODE_TWO_CAPTURE_TRIGGER);
  assign sh_start = cfg.flash_after ? 20'h00001 : ext(fl_act) + 20'h00001;
  assign fl_start = cfg.flash_after ? ext(fl_act) + 20'h00001 : ext(fl_act);
  assign sh_end   = sh_start + ext(sh_len);
  assign cap_finish = cap_active & fl_started & ~flash & (t_us >= sh_end);
  assign set_done = cap_finish & ~pend_a & ~pend_b &
                    (two_cam ? ((got_a | ~cur_b) & (got_b | cur_b)) : 1'b1);
  assign proc_end = proc_busy & proc_done_cmd;

  // capture-done flags and pending requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_done_a <= 1'b1;
      capture_done_b <= 1'b1;
      pend_a         <= 1'b0;
      pend_b         <= 1'b0;
      got_a          <= 1'b0;
      got_b          <= 1'b0;
    end else begin
      if (cap_finish) begin
        if (cur_b) got_b <= 1'b1;
        else       got_a <= 1'b1;
        if (cfg.mode != MODE_ONE_CAPTURE_TRIGGER) begin
          if (cur_b) capture_done_b <= 1'b1;
          else       capture_done_a <= 1'b1;
        end
      end
      if (set_done) begin
        got_a <= 1'b0;
        got_b <= 1'b0;
        if (cfg.mode == MODE_ONE_CAPTURE_TRIGGER) begin
          capture_done_a <= 1'b1;
          capture_done_b <= 1'b1;
        end
      end
      if (acc_a) begin
        capture_done_a <= 1'b0;
        pend_a         <= 1'b1;
        if (cfg.mode == MODE_ONE_CAPTURE_TRIGGER) begin
          capture_done_b <= 1'b0;
          pend_b         <= 1'b1;
        end
      end
      if (acc_b) begin
        capture_done_b <= 1'b0;
        pend_b         <= 1'b1;
      end
      if (~cap_active & pend_a) pend_a <= acc_a;
      else if (~cap_active & pend_b) pend_b <= acc_b;
    end
  end

  // ==========================================================================
  // capture engine; camera a wins, so a held second trigger waits its turn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_active <= 1'b0;
      cur_b      <= 1'b0;
      t_us       <= 20'h00000;
      fl_started <= 1'b0;
      flash      <= 1'b0;
      fl_cnt     <= 16'h0000;
    end else if (~cap_active) begin
      t_us       <= 20'h00000;
      fl_started <= 1'b0;
      flash      <= 1'b0;
      if (pend_a | pend_b) begin
        cap_active <= 1'b1;
        cur_b      <= ~pend_a;
      end
    end else begin
      if (tick_us) t_us <= t_us + 20'h00001;
      if (~fl_started & (t_us >= fl_start)) begin
        fl_started <= 1'b1;
        flash      <= 1'b1;
        fl_cnt     <= fl_dur;
      end else if (flash) begin
        if (fl_cnt == 16'h0000) flash <= 1'b0;
        else if (tick_100us) fl_cnt <= fl_cnt - 16'h0001;
      end
      if (cap_finish) cap_active <= 1'b0;
    end
  end

  // flash held on when its length outlasts the whole frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_always <= 1'b0;
    end else begin
      flash_always <= ({8'h00, fl_dur} * 24'(US_PER_100US)) >
                      (24'(sh_len) + 24'(REFRESH_US) + 24'(PROC_US));
    end
  end

  // camera side outputs, all flopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutter_internal_a <= 1'b0;
      shutter_internal_b <= 1'b0;
      light_strobe_a     <= 1'b0;
      light_strobe_b     <= 1'b0;
    end else begin
      shutter_internal_a <= cap_active & ~cur_b & (t_us >= sh_start) & (t_us < sh_end);
      shutter_internal_b <= cap_active & cur_b & (t_us >= sh_start) & (t_us < sh_end);
      light_strobe_a     <= (flash & ~cur_b) | flash_always;
      light_strobe_b     <= (flash & cur_b) | (flash_always & two_cam);
    end
  end

  // ==========================================================================
  // processing bookkeeping and ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_busy  <= 1'b0;
      buf_full   <= 1'b0;
      cap_during <= 1'b0;
    end else begin
      if (proc_end) begin
        cap_during <= 1'b0;
        proc_busy  <= buf_full | set_done;
        buf_full   <= 1'b0;
      end else if (set_done) begin
        if (proc_busy) begin
          buf_full   <= 1'b1;
          cap_during <= 1'b1;
        end else begin
          proc_busy <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready     <= 1'b1;
      ready_cnt <= 16'h0000;
    end else begin
      if (tick_ms & (ready_cnt != 16'h0000)) begin
        ready_cnt <= ready_cnt - 16'h0001;
        if (ready_cnt == 16'h0001) ready <= 1'b0;
      end
      if (acc_a | acc_b) begin
        ready     <= 1'b0;
        ready_cnt <= 16'h0000;
      end
      if (proc_end) begin
        ready     <= 1'b1;
        ready_cnt <= cap_during ? ready_t : 16'h0000;
      end
    end
  end

  // ==========================================================================
  // parallel result port
  assign out_start = (out_st == OUT_IDLE) & (proc_end | start_pend);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pend <= 1'b0;
    end else if (proc_end & (~out_start | start_pend)) begin // set wins over a take
      start_pend <= 1'b1;
    end else if (out_start) begin
      start_pend <= 1'b0;
    end
  end

  // a busy port postpones the next result rather than cutting the current one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_st             <= OUT_IDLE;
      out_cnt            <= 16'h0000;
      data_cnt           <= 16'h0000;
      result_strobe      <= 1'b0;
      result_lines       <= 16'h0000;
      overall_result_out <= 1'b0;
      error_out          <= 1'b0;
      error_led          <= 1'b0;
    end else begin
      if (tick_ms & (out_cnt != 16'h0000)) out_cnt <= out_cnt - 16'h0001;
      if (tick_ms & (data_cnt != 16'h0000)) data_cnt <= data_cnt - 16'h0001;
      unique case (out_st)
        OUT_IDLE: begin
          if (out_start) begin
            result_lines       <= res_lines;
            overall_result_out <= res_all;
            error_out          <= 1'b0;
            error_led          <= 1'b0;
            out_cnt            <= str_dly;
            data_cnt           <= data_dur;
            out_st             <= OUT_DELAY;
          end
        end
        OUT_DELAY: begin
          if (out_cnt == 16'h0000) begin
            result_strobe <= 1'b1;
            out_cnt       <= cfg.handshake ? tmo : str_len;
            out_st        <= OUT_STROBE;
          end
        end
        OUT_STROBE: begin
          if (cfg.handshake & ack_lvl) begin
            result_strobe <= 1'b0;
            out_st        <= OUT_RELEASE;
          end else if (out_cnt == 16'h0000) begin
            result_strobe <= 1'b0;
            if (cfg.handshake) begin
              error_out <= 1'b1;
              error_led <= 1'b1;
              out_st    <= OUT_RELEASE;
            end else begin
              out_st <= OUT_HOLD;
            end
          end
        end
        OUT_HOLD: begin
          if (data_cnt == 16'h0000) out_st <= OUT_IDLE;
        end
        OUT_RELEASE: begin
          if (~ack_lvl) out_st <= OUT_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: trigger_io_monitor.sv */
// Purpose: port checks for the trigger and result sequencer
// Assumes: one pclk domain, async active-low reset
// Notes:   mirrors ctrl bits from apb writes
module trigger_io_monitor
  import trigger_io_pkg::*;
(
  input wire logic                     pclk, presetn, pready, capture_trigger_a, ack_in,
  input wire trigger_io_pkg::apb_req_t apb,
  input wire logic                     capture_done_a, capture_done_b, ready, error_out,
  input wire logic                     shutter_internal_a, shutter_internal_b, error_led,
  input wire logic                     light_strobe_a, result_strobe,
  input wire logic [15:0]              result_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fa, hs, bf;
  // ==========================================================
  // ctrl mirror, taken only on a completed write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {hs, fa, bf} <= 3'b000;
    else if (apb.psel && apb.penable && pready && apb.pwrite && apb.paddr == OFF_CTRL)
      {hs, fa, bf} <= apb.pwdata[CTRL_HS_BIT:CTRL_BUF_BIT];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ack_seen_s; hs && $rose(ack_in); endsequence
  sequence strobe_drop_s; ##[1:5] !result_strobe; endsequence
  a_take_capture_trigger: assert property ($fell(capture_done_a) |-> $past(capture_trigger_a, 3))
    else $error("capture done fell without a trigger");
  a_ready_drop: assert property ($fell(ready) && !bf |-> $fell(capture_done_a) || $fell(capture_done_b))
    else $error("ready fell without an accepted trigger");
  a_flash_lead: assert property ($rose(shutter_internal_a) && !fa |-> light_strobe_a)
    else $error("shutter opened before flash");
  a_shutter_lead: assert property ($rose(light_strobe_a) && fa |-> shutter_internal_a)
    else $error("flash started before shutter");
  a_one_shutter: assert property (!(shutter_internal_a && shutter_internal_b))
    else $error("two shutters open at once");
  a_done_end: assert property ($rose(capture_done_a) |-> !shutter_internal_a)
    else $error("capture done while shutter open");
  a_strobe_ack: assert property (ack_seen_s |-> strobe_drop_s)
    else $error("strobe stayed high after acknowledge");
  a_data_hold: assert property (hs && $changed(result_lines) |-> !ack_in)
    else $error("result lines changed with acknowledge high");
  a_error_led: assert property ($rose(error_out) |-> error_led && !result_strobe)
    else $error("error raised without indicator or strobe drop");
endmodule

bind trigger_io_seq trigger_io_monitor mon (.pclk(pclk), .presetn(presetn), .pready(pready),
  .capture_trigger_a(capture_trigger_a), .ack_in(ack_in), .apb(apb), .ready(ready),
  .capture_done_a(capture_done_a), .capture_done_b(capture_done_b), .error_out(error_out),
  .shutter_internal_a(shutter_internal_a), .shutter_internal_b(shutter_internal_b),
  .error_led(error_led), .light_strobe_a(light_strobe_a), .result_strobe(result_strobe),
  .result_lines(result_lines));

/* File: host_model.sv */
// Purpose: host controller model, triggers and acknowledge
// Assumes: bench spaces the fire requests
// Notes:   ack is prompt or slow, never dropped early
module host_model (
  input  wire logic pclk, fire_a, fire_b, slow, result_strobe, // from bench and block
  output logic      capture_trigger_a, capture_trigger_b,       // trigger pins
  output logic      ack_in = 1'b0                               // acknowledge pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] wa = '0, wb = '0;
  logic [7:0] cnt = '0;
  // ==========================================================
  // long pins so the synchroniser never misses an edge
  always_ff @(posedge pclk) begin
    wa <= fire_a ? 6'd40 : wa - 6'(wa != 0);
    wb <= fire_b ? 6'd40 : wb - 6'(wb != 0);
  end
  assign capture_trigger_a = wa != 0;
  assign capture_trigger_b = wb != 0;
  // ack held until strobe is seen low
  always_ff @(posedge pclk) begin
    cnt <= result_strobe ? cnt + 8'd1 : 8'd0;
    ack_in <= result_strobe && (ack_in || cnt == (slow ? 8'd90 : 8'd2));
  end
endmodule

/* File: inspection_trigger_io_sequencer_test.sv */
// Purpose: self-checking bench for the sequencer
// Assumes: small us and ms settings keep the run short
// Notes:   results checked from queues by a watcher
module inspection_trigger_io_sequencer_test;
  import trigger_io_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, fire_a = 0, fire_b = 0, slow = 0, strobe_q = 0, both;
  apb_req_t req = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, ta, tb, ack, done_a, done_b, rdy, sa, sb, fla, flb, strb, ovr, eo, el;
  logic [15:0] lines;
  logic [32:0] rq[$], oq[$];
  logic [7:0] ctl[3] = '{8'h14, 8'h1A, 8'h11};
  int err_total = 0, checks = 0, seed = 28385;
  trigger_io_seq uut (.pclk(pclk), .presetn(presetn), .apb(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_trigger_a(ta), .capture_trigger_b(tb),
    .ack_in(ack), .capture_done_a(done_a), .capture_done_b(done_b), .ready(rdy),
    .shutter_internal_a(sa), .shutter_internal_b(sb), .light_strobe_a(fla),
    .light_strobe_b(flb), .result_strobe(strb), .result_lines(lines),
    .overall_result_out(ovr), .error_out(eo), .error_led(el));
  host_model far (.pclk(pclk), .fire_a(fire_a), .fire_b(fire_b), .slow(slow),
    .result_strobe(strb), .capture_trigger_a(ta), .capture_trigger_b(tb), .ack_in(ack));
  // ==========================================================
  // clock, and both cameras idle
  initial forever #5 pclk = ~pclk;
  always_comb both = done_a & done_b;
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // apb master: holds the request until pready is seen
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    req <= '0;
  endtask
  // bounded wait on a level
  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 30000) err_total++;
  endtask
  task automatic wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watcher: oldest note against what appears
  always @(posedge pclk) begin
    if (pready === 1'b1 && !req.pwrite && rq.size() > 0) chk(rq.pop_front(), {pslverr, prdata});
    if (strb === 1'b1 && strobe_q !== 1'b1 && oq.size() > 0) chk(oq.pop_front(), {ovr, lines});
    strobe_q = strb;
  end
  // buffered single, dual on one trigger, two triggers b first
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(33'h0_0000_0003, {31'h0, done_a, rdy});
    rq.push_back({1'b0, RST_FLASH_DUR, RST_FLASH_ACT});
    apb_xfer(1'b0, OFF_FLASH, 32'h0);
    rq.push_back(33'h1_0000_0000);
    apb_xfer(1'b0, 8'h24, 32'h0);
    apb_xfer(1'b1, OFF_SHUTTER, 32'h0000_0002);
    apb_xfer(1'b1, OFF_FLASH, 32'h0001_0001);
    apb_xfer(1'b1, OFF_STROBE, 32'h0001_0000);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      apb_xfer(1'b1, OFF_CTRL, {24'h0, ctl[i]});
      apb_xfer(1'b1, OFF_RESULT, {15'h0, r[16:0]});
      oq.push_back({16'h0, r[16:0]});
      apb_xfer(1'b1, OFF_DATA, i < 2 ? 32'h0005_0001 : 32'h0000_0001);
      slow <= i[0];
      fire_b <= ctl[i][0];
      @(posedge pclk);
      fire_b <= 1'b0;
      fire_a <= 1'b1;
      @(posedge pclk);
      fire_a <= 1'b0;
      wait_on(both, 1'b0);
      chk(33'h0, {32'h0, rdy});
      wait_on(both, 1'b1);
      apb_xfer(1'b1, OFF_CMD, 32'h0000_0001);
      wait_on(rdy, 1'b1);
      wait_on(strb, 1'b1);
      wait_on(strb, 1'b0);
      wait_on(ack, 1'b0);
      chk({31'h0, i == 2, i == 2}, {31'h0, eo, el});
    end
    repeat (20) @(posedge pclk);
    wrap_up;
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    wrap_up;
  end
endmodule
